/* core/scs_supervisor.sv */
`timescale 1ns/1ps
module scs_supervisor
  import scs_pkg::*;
#(
  parameter logic [TMR_W-1:0] INTR_LEN     = TMR_W'(INTR_CYC), // [R21]
  parameter logic [TMR_W-1:0] PWRUP_LEN    = TMR_W'(PWRUP_CYC),
  parameter logic [TMR_W-1:0] RSTPULSE_LEN = TMR_W'(RSTPULSE_CYC),
  parameter logic [TMR_W-1:0] START_LEN    = TMR_W'(START_CYC),
  parameter logic [TMR_W-1:0] BRAKE_LEN    = TMR_W'(BRAKE_CYC),
  parameter logic [TMR_W-1:0] WD_LEN       = TMR_W'(WD_LIMIT_CYC)
) (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       ce_i,
  input  wire logic       undervoltage_sense_i,
  input  wire logic       overtemp_i,
  input  wire logic [2:0] emf_cmp_i,
  input  wire logic       diode_pulse_i,
  input  wire logic       preposition_i,
  input  wire logic       driver_off_test_input_i,
  input  wire logic       stiction_breakaway_enable_i,
  input  wire logic [5:0] xtor_hot_i,
  output logic [1:0]      phase_a_output_o,
  output logic [1:0]      phase_b_output_o,
  output logic [1:0]      phase_c_output_o,
  output logic            upper_conv_en_o,
  output logic            system_reset_n_out_o,
  output logic            retract_o,
  output logic            tacho_pulse_o,
  output logic            reverse_rotation_o
);

  // ------------------------------------------------------------------
  // Supply supervision and reset pulse
  // ------------------------------------------------------------------
  logic [8:0]       uv_cnt;
  logic             uv_filt;
  logic             uv_was;
  logic [TMR_W-1:0] intr_cnt;
  logic             intr_long;
  logic             pu_pend;
  logic             hold_load;
  logic             hold_busy;
  logic [TMR_W-1:0] hold_len;
  logic             uv_end;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      uv_cnt  <= '0;
      uv_filt <= 1'b0;
    end else if (ce_i) begin
      if (!undervoltage_sense_i) begin
        uv_cnt  <= '0;
        uv_filt <= 1'b0;
      end else if (uv_cnt == UV_FILT_CYC) begin
        uv_filt <= 1'b1; // [R1]
      end else begin
        uv_cnt <= uv_cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      uv_was    <= 1'b0;
      intr_cnt  <= '0;
      intr_long <= 1'b0;
      pu_pend   <= 1'b1;
    end else if (ce_i) begin
      uv_was  <= uv_filt;
      pu_pend <= 1'b0;
      if (!uv_filt) begin
        intr_cnt  <= '0;
        intr_long <= 1'b0;
      end else if (intr_cnt == INTR_LEN) begin
        intr_long <= 1'b1; // [R19]
      end else begin
        intr_cnt <= intr_cnt + 1'b1;
      end
    end
  end

  assign uv_end    = uv_was && !uv_filt;
  assign hold_load = pu_pend || (uv_end && intr_long); // [R18] [R19]
  assign hold_len  = pu_pend ? PWRUP_LEN : RSTPULSE_LEN;

  scs_tmr u_reset_pulse_width_timer (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .ce_i    (ce_i),
    .load_i  (hold_load),
    .len_i   (hold_len),
    .run_i   (1'b1),
    .busy_o  (hold_busy),
    .done_o  ()
  );

  // ------------------------------------------------------------------
  // Park-then-brake shutdown
  // ------------------------------------------------------------------
  scs_sd_t sd_state;
  logic    fault_sd;
  logic    brake_done;

  assign fault_sd = uv_filt || overtemp_i; // [R1] [R4]

  scs_tmr u_retract_to_brake_timer (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .ce_i    (ce_i),
    .load_i  (sd_state == SCS_SD_RUN && fault_sd),
    .len_i   (BRAKE_LEN),
    .run_i   (sd_state == SCS_SD_PARK),
    .busy_o  (),
    .done_o  (brake_done)
  );

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      sd_state <= SCS_SD_RUN;
    end else if (ce_i) begin
      unique case (sd_state)
        SCS_SD_RUN: begin
          if (fault_sd) sd_state <= SCS_SD_PARK; // [R2] [R4]
        end
        SCS_SD_PARK: begin
          if (brake_done) sd_state <= SCS_SD_BRAKE; // [R3]
        end
        SCS_SD_BRAKE: begin
          if (!fault_sd && !uv_end && !hold_busy) sd_state <= SCS_SD_RUN;
        end
        default: sd_state <= SCS_SD_RUN;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Commutation pattern and EMF selection
  // ------------------------------------------------------------------
  scs_cm_t    cm_state;
  logic [2:0] src;
  logic [2:0] snk;
  logic [2:0] flt;
  logic       tgt_pol;
  logic       sel_emf;
  logic       wrong;
  logic       comm;
  logic       zc;
  logic       st_done;
  logic       dly_done;
  logic       wd_lim;

  always_comb begin
    unique case (cm_state)
      SCS_CM_AB: begin src = 3'h1; snk = 3'h2; tgt_pol = 1'b0; end
      SCS_CM_AC: begin src = 3'h1; snk = 3'h4; tgt_pol = 1'b1; end
      SCS_CM_BC: begin src = 3'h2; snk = 3'h4; tgt_pol = 1'b0; end
      SCS_CM_BA: begin src = 3'h2; snk = 3'h1; tgt_pol = 1'b1; end
      SCS_CM_CA: begin src = 3'h4; snk = 3'h1; tgt_pol = 1'b0; end
      SCS_CM_CB: begin src = 3'h4; snk = 3'h2; tgt_pol = 1'b1; end
      default:   begin src = 3'h1; snk = 3'h2; tgt_pol = 1'b0; end
    endcase
  end

  assign flt     = ~(src | snk);            // [R5]
  assign sel_emf = |(emf_cmp_i & flt);      // [R6]
  assign wrong   = (sel_emf != tgt_pol);
  assign comm    = dly_done || st_done || wd_lim; // [R7] [R9] [R22]

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cm_state <= SCS_CM_AB;
    end else if (ce_i && comm && sd_state == SCS_SD_RUN) begin
      cm_state <= scs_cm_t'({cm_state[4:0], cm_state[5]}); // [R5]
    end
  end

  scs_tmr u_startup_oscillator_timer (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .ce_i    (ce_i),
    .load_i  (comm), // [R8]
    .len_i   (START_LEN),
    .run_i   (1'b1),
    .busy_o  (),
    .done_o  (st_done)
  );

  // ------------------------------------------------------------------
  // Blanking, zero-crossing and watchdog
  // ------------------------------------------------------------------
  logic [9:0]       blk_cnt;
  logic             armed;
  logic             zc_seen;
  logic [TMR_W-1:0] wd_cnt;

  assign armed = (blk_cnt == WD_BLANK_CYC);
  assign zc    = armed && !zc_seen && !wrong;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      blk_cnt <= '0;
      zc_seen <= 1'b0;
    end else if (ce_i) begin
      if (comm) begin
        blk_cnt <= '0;
        zc_seen <= 1'b0;
      end else begin
        if (!armed) blk_cnt <= blk_cnt + 1'b1;
        if (zc) zc_seen <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      wd_cnt <= '0;
      wd_lim <= 1'b0;
    end else if (ce_i) begin
      wd_lim <= 1'b0;
      if (comm || !armed || zc_seen || !wrong) begin
        wd_cnt <= '0; // [R13]
      end else if (wd_cnt == WD_LEN - 1'b1) begin
        wd_cnt <= '0; // [R13]
        wd_lim <= 1'b1; // [R22]
      end else begin
        wd_cnt <= wd_cnt + 1'b1; // [R13]
      end
    end
  end

  // ------------------------------------------------------------------
  // Adaptive commutation delay
  // ------------------------------------------------------------------
  logic [MEAS_W-1:0] delay_measure_timer;
  logic [MEAS_W-1:0] dly_val;
  logic [MEAS_W-1:0] delay_repeat_timer;
  logic              dly_act;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      delay_measure_timer <= '0;
      dly_val             <= '0;
    end else if (ce_i) begin
      if (comm) begin
        dly_val             <= delay_measure_timer >> 1; // [R10] [R11]
        delay_measure_timer <= '0;
      end else if (!diode_pulse_i && delay_measure_timer != MEAS_SAT) begin
        delay_measure_timer <= delay_measure_timer + 1'b1; // [R10] [R11]
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      delay_repeat_timer <= '0;
      dly_act            <= 1'b0;
    end else if (ce_i) begin
      if (comm) begin
        dly_act <= 1'b0;
      end else if (zc) begin
        delay_repeat_timer <= '0; // [R7]
        dly_act            <= 1'b1;
      end else if (dly_act && !dly_done) begin
        delay_repeat_timer <= delay_repeat_timer + 1'b1; // [R12]
      end
    end
  end

  assign dly_done = dly_act && (delay_repeat_timer >= dly_val); // [R7]

  // ------------------------------------------------------------------
  // Output drivers, tacho and reset output
  // ------------------------------------------------------------------
  logic [2:0] drv_hi;
  logic [2:0] drv_lo;
  logic [2:0] next_hi;
  logic [2:0] next_lo;
  logic       test_off;
  logic       any_hot;
  logic       next_rst_n;

  assign test_off = driver_off_test_input_i && !stiction_breakaway_enable_i;
  assign any_hot  = |(xtor_hot_i & {drv_hi, drv_lo}); // [R17]

  always_comb begin
    if (sd_state == SCS_SD_PARK || test_off) begin
      next_hi = 3'h0; // [R2] [R16]
      next_lo = 3'h0;
    end else if (sd_state == SCS_SD_BRAKE) begin
      next_hi = 3'h0; // [R3]
      next_lo = 3'h7;
    end else if (preposition_i) begin
      next_hi = 3'h4; // [R15]
      next_lo = 3'h2;
    end else begin
      next_hi = src; // [R5]
      next_lo = snk;
    end
    next_hi = next_hi & ~xtor_hot_i[5:3]; // [R17]
    next_lo = next_lo & ~xtor_hot_i[2:0];
  end

  assign next_rst_n = !(fault_sd || sd_state != SCS_SD_RUN || test_off ||
                        any_hot || hold_busy || hold_load);

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      drv_hi               <= 3'h0;
      drv_lo               <= 3'h0;
      upper_conv_en_o      <= 1'b0;
      system_reset_n_out_o <= 1'b0;
      retract_o            <= 1'b1;
    end else if (ce_i) begin
      drv_hi               <= next_hi;
      drv_lo               <= next_lo;
      upper_conv_en_o      <= (sd_state == SCS_SD_RUN) && !fault_sd; // [R2]
      system_reset_n_out_o <= next_rst_n; // [R1] [R16] [R17] [R18]
      retract_o            <= !next_rst_n; // [R20]
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      tacho_pulse_o      <= 1'b1;
      reverse_rotation_o <= 1'b0;
    end else if (ce_i) begin
      if (comm) tacho_pulse_o <= 1'b1; // [R14]
      else if (zc) tacho_pulse_o <= 1'b0; // [R14]
      if (wd_lim) reverse_rotation_o <= 1'b1; // [R22]
      else if (zc) reverse_rotation_o <= 1'b0;
    end
  end

  assign phase_a_output_o = {drv_hi[0], drv_lo[0]};
  assign phase_b_output_o = {drv_hi[1], drv_lo[1]};
  assign phase_c_output_o = {drv_hi[2], drv_lo[2]};

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i || !ce_i);

  a_uv_reset_low: assert property ( // [R1]
    uv_filt |=> !system_reset_n_out_o && retract_o)
    else $error("undervoltage did not pull reset low");
  a_park_floats: assert property ( // [R2]
    sd_state == SCS_SD_PARK |=> drv_hi == 3'h0 && drv_lo == 3'h0
      && !upper_conv_en_o)
    else $error("park step left a driver or converter on");
  a_brake_lower_on: assert property ( // [R3]
    sd_state == SCS_SD_BRAKE && xtor_hot_i == 6'h00 && !test_off
      |=> drv_lo == 3'h7 && drv_hi == 3'h0)
    else $error("brake step did not short the windings");
  a_hot_starts_park: assert property ( // [R4]
    sd_state == SCS_SD_RUN && overtemp_i |=> sd_state == SCS_SD_PARK)
    else $error("overtemperature did not start shutdown");
  a_one_src_snk: assert property ( // [R5]
    sd_state == SCS_SD_RUN && !fault_sd && !test_off && !preposition_i
      && xtor_hot_i == 6'h00
      |=> $onehot(drv_hi) && $onehot(drv_lo) && (drv_hi & drv_lo) == 3'h0)
    else $error("drive pattern is not one source and one sink");
  a_tacho_fall: assert property ( // [R14]
    zc && !comm |=> !tacho_pulse_o)
    else $error("tacho did not fall on a crossing");
  a_tacho_rise: assert property ( // [R14]
    comm |=> tacho_pulse_o)
    else $error("tacho did not rise on a commutation");
  a_preset_pattern: assert property ( // [R15]
    preposition_i && sd_state == SCS_SD_RUN && !fault_sd && !test_off
      && xtor_hot_i == 6'h00 |=> drv_hi == 3'h4 && drv_lo == 3'h2)
    else $error("preposition pattern wrong");
  a_test_off_reset: assert property ( // [R16]
    test_off |=> drv_hi == 3'h0 && drv_lo == 3'h0 && !system_reset_n_out_o)
    else $error("test input did not switch drivers off");
  a_hot_xtor_off: assert property ( // [R17]
    any_hot |=> !system_reset_n_out_o
      && (({drv_hi, drv_lo} & $past(xtor_hot_i)) == 6'h00))
    else $error("overheated transistor left on");
  a_wd_advance: assert property ( // [R22]
    wd_lim && sd_state == SCS_SD_RUN
      |=> reverse_rotation_o && cm_state != $past(cm_state))
    else $error("watchdog limit did not advance and flag");

  c_brake_reached: cover property (
    sd_state == SCS_SD_PARK ##1 sd_state == SCS_SD_BRAKE);
  c_delay_commute: cover property (dly_done && sd_state == SCS_SD_RUN);
  c_watchdog_hit: cover property (wd_lim);
  c_start_pulse: cover property (st_done && !dly_done);

endmodule : scs_supervisor

/* core/scs_pkg.sv */
// Functional notes
// R1: Undervoltage over 1 us forces reset and shutdown.
// R2: Shutdown step one: windings float, converter off.
// R3: Step two after brake delay: lower transistors on.
// R4: Overtemperature runs the same two-step shutdown.
// R5: Six states: one source, one sink, one float.
// R6: Only the floating winding comparator is used.
// R7: Zero-crossing starts delay; delay end commutates.
// R8: Start oscillator pulses, restarted by every commutation.
// R9: Each start pulse advances the commutation state.
// R10: Delay is half the diode-paused period measurement.
// R11: Saturated measurement gives fixed maximum delay.
// R12: Repeat timer reproduces delay at equal rates.
// R13: Watchdog runs after blanking while polarity wrong.
// R14: Tacho falls on zero-crossing, rises on commutation.
// R15: Preposition: phase C high, B low, A floating.
// R16: Test input without enable: drivers off, reset low.
// R17: Overheated conducting transistor off, reset low.
// R18: Power-up holds reset low for 150 ms.
// R19: Interruption over 1 ms gives 100 ms reset.
// R20: Any reset condition also commands head retraction.
// R21: Analog timings become clock counters and parameters.
// R22: Watchdog limit flags reverse rotation and advances.
package scs_pkg;

  // ------------------------------------------------------------------
  // Clock and timing
  // ------------------------------------------------------------------
  localparam int unsigned CLK_MHZ      = 250;
  localparam int unsigned TMR_W        = 26;
  localparam int unsigned MEAS_W       = 20;
  localparam int unsigned UV_FILT_NS   = 1000;
  localparam int unsigned WD_BLANK_NS  = 2000;
  localparam int unsigned INTR_MS      = 1;
  localparam int unsigned PWRUP_MS     = 150;
  localparam int unsigned RSTPULSE_MS  = 100;
  localparam int unsigned START_MS     = 24;
  localparam int unsigned BRAKE_MS     = 50;
  localparam int unsigned WD_LIMIT_MS  = 4;

  localparam logic [8:0]  UV_FILT_CYC  = 9'(UV_FILT_NS * CLK_MHZ / 1000);
  localparam logic [9:0]  WD_BLANK_CYC = 10'(WD_BLANK_NS * CLK_MHZ / 1000);
  localparam int unsigned INTR_CYC     = INTR_MS * CLK_MHZ * 1000;
  localparam int unsigned PWRUP_CYC    = PWRUP_MS * CLK_MHZ * 1000;
  localparam int unsigned RSTPULSE_CYC = RSTPULSE_MS * CLK_MHZ * 1000;
  localparam int unsigned START_CYC    = START_MS * CLK_MHZ * 1000;
  localparam int unsigned BRAKE_CYC    = BRAKE_MS * CLK_MHZ * 1000;
  localparam int unsigned WD_LIMIT_CYC = WD_LIMIT_MS * CLK_MHZ * 1000;

  localparam logic [MEAS_W-1:0] MEAS_SAT = '1;

  // ------------------------------------------------------------------
  // States
  // ------------------------------------------------------------------
  typedef enum logic [2:0] {
    SCS_SD_RUN   = 3'h1,
    SCS_SD_PARK  = 3'h2,
    SCS_SD_BRAKE = 3'h4
  } scs_sd_t;

  typedef enum logic [5:0] {
    SCS_CM_AB = 6'h01,
    SCS_CM_AC = 6'h02,
    SCS_CM_BC = 6'h04,
    SCS_CM_BA = 6'h08,
    SCS_CM_CA = 6'h10,
    SCS_CM_CB = 6'h20
  } scs_cm_t;

endpackage : scs_pkg

/* core/scs_tmr.sv */
`timescale 1ns/1ps
module scs_tmr
  import scs_pkg::*;
(
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  input  wire logic             ce_i,
  input  wire logic             load_i,
  input  wire logic [TMR_W-1:0] len_i,
  input  wire logic             run_i,
  output logic                  busy_o,
  output logic                  done_o
);

  logic [TMR_W-1:0] cnt;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cnt <= '0;
    end else if (ce_i) begin
      if (load_i) begin
        cnt <= len_i;
      end else if (run_i && cnt != '0) begin
        cnt <= cnt - 1'b1;
      end
    end
  end

  assign busy_o = (cnt != '0);
  assign done_o = run_i && !load_i && (cnt == TMR_W'(1));

endmodule : scs_tmr

/* tb/scs_motor_model.sv */
`timescale 1ns/1ps
module scs_motor_model #(
  parameter int ZC_DLY = 600,
  parameter int DIODE  = 40
) (
  input  wire logic       clk_i,
  input  wire logic       stall_i,
  input  wire logic [1:0] phase_a_i,
  input  wire logic [1:0] phase_b_i,
  input  wire logic [1:0] phase_c_i,
  output logic [2:0]      emf_cmp_o,
  output logic            diode_pulse_o
);
  // ------------------------------------------------------------------
  // Winding model
  // ------------------------------------------------------------------
  // The floating winding's EMF crosses ZC_DLY cycles after each change
  // of drive. A stalled rotor never crosses. Driven windings always show
  // the wrong polarity, so a wrongly selected comparator never crosses.
  logic [5:0]  pat;
  logic [5:0]  last = 6'h00;
  logic [15:0] cnt  = 16'h0000;
  int          src;
  int          snk;
  logic        valid;
  logic        pol;

  assign pat = {phase_a_i, phase_b_i, phase_c_i};

  always_ff @(posedge clk_i) begin
    last <= pat;
    if (pat != last) begin
      cnt <= 16'h0000;
    end else if (cnt != 16'hFFFF) begin
      cnt <= cnt + 16'h0001;
    end
  end

  always_comb begin
    src = 3;
    snk = 3;
    for (int k = 0; k < 3; k++) begin
      if (pat[5 - 2 * k]) src = k;
      if (pat[4 - 2 * k]) snk = k;
    end
    valid = ($countones(pat & 6'h2A) == 1) &&
            ($countones(pat & 6'h15) == 1) && (src != snk);
    pol = (((snk - src + 3) % 3) == 2);
    for (int k = 0; k < 3; k++) begin
      // Without a one-source, one-sink drive, every winding shows a level that changes every cycle.
      if (!valid) emf_cmp_o[k] = cnt[0] ^ k[0];
      else if (k == 3 - src - snk && cnt >= ZC_DLY && !stall_i)
        emf_cmp_o[k] = pol;
      else emf_cmp_o[k] = ~pol;
    end
    diode_pulse_o = valid && (cnt < DIODE);
  end
endmodule : scs_motor_model

/* tb/tb_top.sv */
`timescale 1ns/1ps
module tb_top
  import scs_pkg::*;
;
  // ------------------------------------------------------------------
  // Harness
  // ------------------------------------------------------------------
  localparam int INTR = 20, PWRUP = 50, RSTP = 40, START = 3000;
  localparam int BRK = 30, WDL = 200, BLANK = 500, DIODE = 40;
  logic       clk = 0, rst_n = 0, uv = 0, ot = 0, prepos = 0;
  logic       test_in = 0, stiction = 0, stall = 0;
  logic [5:0] hot = 6'h00;
  logic [2:0] emf;
  logic       diode, conv_en, rst_out_n, retract, tacho, reverse;
  logic [1:0] ph_a, ph_b, ph_c;
  logic [5:0] pat;
  int         n_fail = 0, compares = 0, cyc_n = 0;

  assign pat = {ph_a, ph_b, ph_c};

  scs_supervisor #(
    .INTR_LEN    (TMR_W'(INTR)),
    .PWRUP_LEN   (TMR_W'(PWRUP)),
    .RSTPULSE_LEN(TMR_W'(RSTP)),
    .START_LEN   (TMR_W'(START)),
    .BRAKE_LEN   (TMR_W'(BRK)),
    .WD_LEN      (TMR_W'(WDL))
  ) u_scs_supervisor (
    .clk_i(clk), .rst_n_i(rst_n), .ce_i(1'b1),
    .undervoltage_sense_i(uv), .overtemp_i(ot), .emf_cmp_i(emf),
    .diode_pulse_i(diode), .preposition_i(prepos),
    .driver_off_test_input_i(test_in),
    .stiction_breakaway_enable_i(stiction), .xtor_hot_i(hot),
    .phase_a_output_o(ph_a), .phase_b_output_o(ph_b),
    .phase_c_output_o(ph_c), .upper_conv_en_o(conv_en),
    .system_reset_n_out_o(rst_out_n), .retract_o(retract),
    .tacho_pulse_o(tacho), .reverse_rotation_o(reverse)
  );

  scs_motor_model #(.ZC_DLY(BLANK + 100), .DIODE(DIODE)) u_scs_motor_model (
    .clk_i(clk), .stall_i(stall), .phase_a_i(ph_a), .phase_b_i(ph_b),
    .phase_c_i(ph_c), .emf_cmp_o(emf), .diode_pulse_o(diode)
  );

  always #2 clk = ~clk;
  always @(posedge clk) cyc_n <= cyc_n + 1;

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  task automatic chk(input string what, input logic [7:0] seen,
                     input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  function automatic logic [7:0] rng(input int v, input int lo, input int hi);
    return (v >= lo && v <= hi) ? 8'h01 : 8'h00;
  endfunction : rng

  function automatic logic probe(input int i);
    case (i)
      0: return tacho;
      1: return rst_out_n;
      default: return reverse;
    endcase
  endfunction : probe

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc

  task automatic wait_on(input int i, input logic lvl, input int lim,
                         output int k);
    k = 0;
    while (probe(i) !== lvl && k < lim) begin
      @(negedge clk);
      k++;
    end
    chk("wait_limit", rng(k, 0, lim - 1), 8'h01);
  endtask : wait_on

  task automatic wait_pat(input logic [5:0] exp, input int lim, output int k);
    k = 0;
    while (pat !== exp && k < lim) begin
      @(negedge clk);
      k++;
    end
  endtask : wait_pat

  task automatic close_out();
    $display("checks %0d, mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : close_out

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task automatic t_run();
    int k, tf, tr, prev_tr, per, idx;
    logic [5:0] seq [6] = '{6'h24, 6'h21, 6'h09, 6'h18, 6'h12, 6'h06};
    prev_tr = 0;
    per = 0;
    idx = -1;
    for (int i = 0; i < 8; i++) begin
      wait_on(0, 1'b0, 4000, k);
      tf = cyc_n;
      wait_on(0, 1'b1, 4000, k);
      tr = cyc_n;
      if (i >= 2) chk("zc_delay", rng(tr - tf, (per - DIODE) / 2 - 4,
                      (per - DIODE) / 2 + 4), 8'h01);
      per = tr - prev_tr;
      prev_tr = tr;
      cyc(3);
      if (idx >= 0) chk("pattern", {2'h0, pat}, {2'h0, seq[(idx + 1) % 6]});
      idx = -1;
      for (int j = 0; j < 6; j++) if (seq[j] === pat) idx = j;
    end
    $display("test run done");
  endtask : t_run

  task automatic t_watchdog();
    int k;
    logic [5:0] p0;
    stall = 1'b1;
    cyc(1);
    p0 = pat;
    wait_on(0, 1'b1, 4000, k);
    while (pat === p0 && k < 8000) begin
      @(negedge clk);
      k++;
    end
    p0 = pat;
    k = 0;
    while (pat === p0 && k < 4000) begin
      @(negedge clk);
      k++;
    end
    chk("wd_interval", rng(k, BLANK + WDL - 2, BLANK + WDL + 6), 8'h01);
    cyc(2);
    chk("reverse_set", {7'h0, reverse}, 8'h01);
    chk("tacho_high", {7'h0, tacho}, 8'h01);
    stall = 1'b0;
    wait_on(0, 1'b0, 4000, k);
    cyc(2);
    chk("reverse_clr", {7'h0, reverse}, 8'h00);
    $display("test watchdog done");
  endtask : t_watchdog

  task automatic t_pins();
    int k;
    prepos = 1'b1;
    cyc(3);
    chk("preposition", {2'h0, pat}, 8'h06);
    prepos = 1'b0;
    stiction = 1'b1;
    test_in = 1'b1;
    cyc(4);
    chk("test_masked", {7'h0, rst_out_n}, 8'h01);
    chk("drive_kept", {7'h0, pat !== 6'h00}, 8'h01);
    stiction = 1'b0;
    cyc(3);
    chk("test_off", {pat, rst_out_n, retract}, 8'h01);
    test_in = 1'b0;
    wait_on(1, 1'b1, 200, k);
    chk("test_release", {7'h0, rst_out_n}, 8'h01);
    hot = 6'h38;
    // Reset drops for one cycle: once off, the transistor no longer counts.
    cyc(1);
    chk("hot_reset", {7'h0, rst_out_n}, 8'h00);
    cyc(2);
    chk("hot_upper", {2'h0, pat & 6'h2A}, 8'h00);
    hot = 6'h00;
    wait_on(1, 1'b1, 200, k);
    $display("test pins done");
  endtask : t_pins

  task automatic t_supply();
    int k;
    uv = 1'b1;
    cyc(200);
    uv = 1'b0;
    cyc(3);
    chk("uv_short", {6'h0, rst_out_n, conv_en}, 8'h03);
    uv = 1'b1;
    wait_on(1, 1'b0, 400, k);
    chk("uv_filter", rng(k, 250, 254), 8'h01);
    cyc(2);
    chk("park", {pat, conv_en, retract}, 8'h01);
    wait_pat(6'h15, 100, k);
    chk("brake", rng(k, BRK - 4, BRK + 4), 8'h01);
    uv = 1'b0;
    wait_on(1, 1'b1, 300, k);
    chk("uv_pulse", rng(k, RSTP - 2, RSTP + 10), 8'h01);
    chk("conv_back", {7'h0, conv_en}, 8'h01);
    ot = 1'b1;
    cyc(2);
    chk("ot_reset", {7'h0, rst_out_n}, 8'h00);
    cyc(1);
    chk("ot_park", {pat, conv_en, retract}, 8'h01);
    cyc(5);
    ot = 1'b0;
    wait_pat(6'h15, 100, k);
    chk("ot_brake", rng(k, BRK - 10, BRK + 4), 8'h01);
    wait_on(1, 1'b1, 300, k);
    chk("ot_recover", {7'h0, rst_out_n}, 8'h01);
    $display("test supply done");
  endtask : t_supply

  initial begin
    int k;
    cyc(8);
    chk("reset_state", {rst_out_n, retract, tacho, reverse, conv_en, 3'h0},
        8'h60);
    rst_n = 1'b1;
    wait_on(1, 1'b1, 200, k);
    chk("powerup_hold", rng(k, PWRUP - 2, PWRUP + 6), 8'h01);
    chk("retract_off", {7'h0, retract}, 8'h00);
    $display("test powerup done");
    t_run();
    t_watchdog();
    t_pins();
    t_supply();
    close_out();
  end

  initial begin
    #300000;
    n_fail++;
    close_out();
  end
endmodule : tb_top
